// *** design/audio_clock_generation.sv ***
// audio clock generator: field-locked master clock with bit and channel clocks
//
// How it works
// - 18-bit master cycles per field, 30H-32H
// - 22-bit nominal increment, 34H-36H
// - bit clock from master, ratio 38H
// - channel clock from bit clock, ratio 39H
// - control bit 3: PLL locked or open
// - control bit 2: vertical reference source
// - control bit 1: channel clock launch edge
// - control bit 0: bit clock launch edge
`timescale 1ns/1ps
module audio_clock_generation
  import audio_clock_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // subaddressed register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // vertical references
  input wire logic decoder_vsync_i,
  input wire logic expansion_vertical_ref_in_i,
  // audio clocks
  output logic master_audio_clock_o,
  output logic serial_bit_clock_o,
  output logic channel_select_clock_o
);

  // ==========================================================
  // registers
  logic [CPF_W-1:0] cycles_per_field_q;
  logic [INC_W-1:0] nominal_increment_q;
  logic [RATIO_W-1:0] bit_clock_ratio_q;
  logic [RATIO_W-1:0] channel_clock_ratio_q;
  audio_ctrl_s ctrl_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cycles_per_field_q <= CPF_RESET;
      nominal_increment_q <= INC_RESET;
      bit_clock_ratio_q <= RATIO_RESET;
      channel_clock_ratio_q <= RATIO_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (reg_we_i) begin
      if (reg_addr_i == ADDR_CYCLES_PER_FIELD_LOW) begin
        cycles_per_field_q[7:0] <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_CYCLES_PER_FIELD_MID) begin
        cycles_per_field_q[15:8] <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_CYCLES_PER_FIELD_HIGH) begin
        cycles_per_field_q[17:16] <= reg_wdata_i[CPF_HIGH_W-1:0];
      end else if (reg_addr_i == ADDR_NOMINAL_INCREMENT_LOW) begin
        nominal_increment_q[7:0] <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_NOMINAL_INCREMENT_MID) begin
        nominal_increment_q[15:8] <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_NOMINAL_INCREMENT_HIGH) begin
        nominal_increment_q[21:16] <= reg_wdata_i[INC_HIGH_W-1:0];
      end else if (reg_addr_i == ADDR_BIT_CLOCK_RATIO) begin
        bit_clock_ratio_q <= reg_wdata_i[RATIO_W-1:0];
      end else if (reg_addr_i == ADDR_CHANNEL_CLOCK_RATIO) begin
        channel_clock_ratio_q <= reg_wdata_i[RATIO_W-1:0];
      end else if (reg_addr_i == ADDR_AUDIO_CLOCK_CONTROL) begin
        ctrl_q <= reg_wdata_i[CTRL_W-1:0];
      end
    end
  end

  // ==========================================================
  // read data, one cycle after the read strobe
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr_i == ADDR_CYCLES_PER_FIELD_LOW) begin
      rdata_d = cycles_per_field_q[7:0];
    end else if (reg_addr_i == ADDR_CYCLES_PER_FIELD_MID) begin
      rdata_d = cycles_per_field_q[15:8];
    end else if (reg_addr_i == ADDR_CYCLES_PER_FIELD_HIGH) begin
      rdata_d = {6'h00, cycles_per_field_q[17:16]};
    end else if (reg_addr_i == ADDR_NOMINAL_INCREMENT_LOW) begin
      rdata_d = nominal_increment_q[7:0];
    end else if (reg_addr_i == ADDR_NOMINAL_INCREMENT_MID) begin
      rdata_d = nominal_increment_q[15:8];
    end else if (reg_addr_i == ADDR_NOMINAL_INCREMENT_HIGH) begin
      rdata_d = {2'h0, nominal_increment_q[21:16]};
    end else if (reg_addr_i == ADDR_BIT_CLOCK_RATIO) begin
      rdata_d = {2'h0, bit_clock_ratio_q};
    end else if (reg_addr_i == ADDR_CHANNEL_CLOCK_RATIO) begin
      rdata_d = {2'h0, channel_clock_ratio_q};
    end else if (reg_addr_i == ADDR_AUDIO_CLOCK_CONTROL) begin
      rdata_d = {4'h0, ctrl_q};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // ==========================================================
  // vertical reference selection and edge detection
  logic xrv_meta_q;
  logic xrv_sync_q;
  logic vref_prev_q;
  logic vref_sel;
  logic field_start;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      xrv_meta_q <= 1'b0;
      xrv_sync_q <= 1'b0;
    end else begin
      xrv_meta_q <= expansion_vertical_ref_in_i;
      xrv_sync_q <= xrv_meta_q;
    end
  end

  assign vref_sel = ctrl_q.vertical_ref_source ? xrv_sync_q : decoder_vsync_i;
  assign field_start = vref_sel && !vref_prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      vref_prev_q <= 1'b0;
    end else begin
      vref_prev_q <= vref_sel;
    end
  end

  // ==========================================================
  // master clock synthesis
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic signed [TRIM_W-1:0] trim_q;
  logic [ACC_W-1:0] step;
  clk_edges_s master_q;

  // open loop uses the nominal increment alone
  assign step = ctrl_q.pll_open_select ? ACC_W'(nominal_increment_q)
              : ACC_W'(nominal_increment_q) + ACC_W'(trim_q);
  assign acc_d = acc_q + step;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      acc_q <= '0;
      master_q <= '0;
    end else begin
      acc_q <= acc_d;
      master_q.level <= acc_d[ACC_W-1];
      master_q.rise <= acc_d[ACC_W-1] && !acc_q[ACC_W-1];
      master_q.fall <= !acc_d[ACC_W-1] && acc_q[ACC_W-1];
    end
  end

  // ==========================================================
  // field lock loop
  logic [CPF_W-1:0] field_count_q;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      field_count_q <= '0;
    end else if (field_start) begin
      field_count_q <= '0;
    end else if (master_q.rise && (field_count_q != '1)) begin
      field_count_q <= field_count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || ctrl_q.pll_open_select) begin
      trim_q <= '0;
    end else if (field_start) begin
      if ((field_count_q > cycles_per_field_q) && (trim_q > TRIM_MIN)) begin
        trim_q <= trim_q - 1'b1;
      end else if ((field_count_q < cycles_per_field_q) && (trim_q < TRIM_MAX)) begin
        trim_q <= trim_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // derived clocks
  clk_edges_s bit_clk;
  clk_edges_s chan_clk;

  clock_ratio_divider u_bit_div (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .src_i(master_q),
    .ratio_i(bit_clock_ratio_q),
    .rise_phase_i(ctrl_q.bit_clock_phase),
    .out_o(bit_clk)
  );

  clock_ratio_divider u_chan_div (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .src_i(bit_clk),
    .ratio_i(channel_clock_ratio_q),
    .rise_phase_i(ctrl_q.channel_clock_phase),
    .out_o(chan_clk)
  );

  assign master_audio_clock_o = master_q.level;
  assign serial_bit_clock_o = bit_clk.level;
  assign channel_select_clock_o = chan_clk.level;

endmodule

// *** common/audio_clock_pkg.sv ***
// constants, register map and carriers of the audio clock generator
package audio_clock_pkg;

  // ==========================================================
  // register subaddresses
  localparam logic [7:0] ADDR_CYCLES_PER_FIELD_LOW = 8'h30;
  localparam logic [7:0] ADDR_CYCLES_PER_FIELD_MID = 8'h31;
  localparam logic [7:0] ADDR_CYCLES_PER_FIELD_HIGH = 8'h32;
  localparam logic [7:0] ADDR_NOMINAL_INCREMENT_LOW = 8'h34;
  localparam logic [7:0] ADDR_NOMINAL_INCREMENT_MID = 8'h35;
  localparam logic [7:0] ADDR_NOMINAL_INCREMENT_HIGH = 8'h36;
  localparam logic [7:0] ADDR_BIT_CLOCK_RATIO = 8'h38;
  localparam logic [7:0] ADDR_CHANNEL_CLOCK_RATIO = 8'h39;
  localparam logic [7:0] ADDR_AUDIO_CLOCK_CONTROL = 8'h3A;

  // ==========================================================
  // field widths and positions
  localparam int CPF_W = 18;
  localparam int CPF_HIGH_W = 2;
  localparam int INC_W = 22;
  localparam int INC_HIGH_W = 6;
  localparam int RATIO_W = 6;
  localparam int CTRL_W = 4;
  localparam int BIT_PLL_OPEN = 3;
  localparam int BIT_VREF_SOURCE = 2;
  localparam int BIT_CHANNEL_PHASE = 1;
  localparam int BIT_BIT_PHASE = 0;

  // ==========================================================
  // synthesis accumulator and loop trim
  localparam int ACC_W = 24;
  localparam int TRIM_W = 12;
  localparam logic signed [TRIM_W-1:0] TRIM_MAX = 12'sh7FF;
  localparam logic signed [TRIM_W-1:0] TRIM_MIN = -12'sh7FF;

  // ==========================================================
  // reset values
  localparam logic [CPF_W-1:0] CPF_RESET = 18'h00000;
  localparam logic [INC_W-1:0] INC_RESET = 22'h000000;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 6'h00;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  typedef struct packed {
    logic pll_open_select;
    logic vertical_ref_source;
    logic channel_clock_phase;
    logic bit_clock_phase;
  } audio_ctrl_s;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } clk_edges_s;

endpackage

// *** design/clock_ratio_divider.sv ***
// divides a sampled clock by a programmable ratio, launching on a chosen edge
`timescale 1ns/1ps
module clock_ratio_divider
  import audio_clock_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // source clock edges and settings
  input wire clk_edges_s src_i,
  input wire logic [RATIO_W-1:0] ratio_i,
  input wire logic rise_phase_i,
  // divided clock
  output clk_edges_s out_o
);

  logic [RATIO_W-1:0] cnt_q;
  logic launch;

  // output toggles after ratio+1 launching edges of the source
  assign launch = rise_phase_i ? src_i.rise : src_i.fall;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (launch) begin
      cnt_q <= (cnt_q >= ratio_i) ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      out_o <= '0;
    end else begin
      out_o.rise <= launch && (cnt_q >= ratio_i) && !out_o.level;
      out_o.fall <= launch && (cnt_q >= ratio_i) && out_o.level;
      if (launch && (cnt_q >= ratio_i)) begin
        out_o.level <= !out_o.level;
      end
    end
  end

endmodule

// *** bench/audio_clock_props.sv ***
// port checker for the audio clock generator
`timescale 1ns/1ps
module audio_clock_props
  import audio_clock_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // audio clocks
  input wire logic master_audio_clock_o,
  input wire logic serial_bit_clock_o,
  input wire logic channel_select_clock_o
);
  logic [3:0] ctl_q;
  logic m1_q, m2_q, b1_q, b2_q;
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  // ==========================================================
  // control shadow and edge history
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctl_q <= 4'h0;
    end else if (reg_we_i && reg_addr_i == ADDR_AUDIO_CLOCK_CONTROL) begin
      ctl_q <= reg_wdata_i[3:0];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    m1_q <= master_audio_clock_o;
    m2_q <= m1_q;
    b1_q <= serial_bit_clock_o;
    b2_q <= b1_q;
  end
  // ==========================================================
  // assertions
  ratio_readback_a: assert property (
    reg_we_i && reg_addr_i == 8'h38 ##1 reg_re_i && !reg_we_i && reg_addr_i == 8'h38
    |=> reg_rdata_o == {2'b00, $past(reg_wdata_i[5:0], 2)}) else $error("ratio readback wrong");
  unmapped_zero_a: assert property (
    reg_re_i && (reg_addr_i < 8'h30 || reg_addr_i > 8'h3A || reg_addr_i == 8'h33)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_re_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  bit_launch_a: assert property ($changed(serial_bit_clock_o) |-> (ctl_q[0] ?
    (m1_q && !m2_q) || (master_audio_clock_o && !m1_q) :
    (!m1_q && m2_q) || (!master_audio_clock_o && m1_q))) else $error("bit clock edge misplaced");
  chan_launch_a: assert property ($changed(channel_select_clock_o) |-> (ctl_q[1] ?
    (b1_q && !b2_q) || (serial_bit_clock_o && !b1_q) :
    (!b1_q && b2_q) || (!serial_bit_clock_o && b1_q))) else $error("channel edge misplaced");
  bit_spacing_a: assert property (
    $changed(serial_bit_clock_o) |=> $stable(serial_bit_clock_o) [*2]) else $error("bit too fast");
  chan_spacing_a: assert property (
    $changed(channel_select_clock_o) |=> $stable(channel_select_clock_o) [*5])
    else $error("channel clock too fast");
  reset_quiet_a: assert property (disable iff (1'b0) srst_i |=> !master_audio_clock_o &&
    !serial_bit_clock_o && !channel_select_clock_o) else $error("clocks run in reset");
endmodule
bind audio_clock_generation audio_clock_props props_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .master_audio_clock_o(master_audio_clock_o),
  .serial_bit_clock_o(serial_bit_clock_o), .channel_select_clock_o(channel_select_clock_o));

// *** bench/audio_converter_model.sv ***
// serial audio receiver: counts bit clock rises per channel half
`timescale 1ns/1ps
module audio_converter_model (
  input wire logic clk_sys_i,
  input wire logic sclk_i,
  input wire logic lrclk_i,
  output logic [7:0] bits_o
);
  logic s_q, l_q;
  logic [7:0] cnt_q = 8'h00;
  always_ff @(posedge clk_sys_i) begin
    s_q <= sclk_i;
    l_q <= lrclk_i;
    if (l_q != lrclk_i) begin
      bits_o <= cnt_q;
      cnt_q <= 8'h00;
    end else if (sclk_i && !s_q) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the audio clock generator
`timescale 1ns/1ps
module testbench;
  import audio_clock_pkg::*;
  localparam logic [15:0] RT [8] = '{16'h30FF, 16'h3203, 16'h3300, 16'h363F, 16'h383F,
    16'h393F, 16'h3A0F, 16'h3B00};
  localparam logic [11:0] CS [5] = '{12'h018, 12'h419, 12'h039, 12'hC18, 12'h458};
  logic clk_sys_i = 1'b0, srst_i = 1'b1, we = 1'b0, re = 1'b0;
  logic dv = 1'b0, expansion_vertical_ref_in = 1'b0, xen = 1'b0, den = 1'b0, mc, sc, lc;
  logic [7:0] a = 8'h00, wd = 8'h00, rd, bits;
  int fails = 0, tests_run = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  initial #7 forever #160 expansion_vertical_ref_in = xen & ~expansion_vertical_ref_in;
  always @(posedge clk_sys_i) dv <= #1 den & expansion_vertical_ref_in;
  audio_clock_generation dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(a),
    .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .decoder_vsync_i(dv),
    .expansion_vertical_ref_in_i(expansion_vertical_ref_in), .master_audio_clock_o(mc), .serial_bit_clock_o(sc),
    .channel_select_clock_o(lc));
  audio_converter_model conv_u (.clk_sys_i(clk_sys_i), .sclk_i(sc), .lrclk_i(lc), .bits_o(bits));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rst();
    srst_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    a = ad;
    wd = d;
    we = 1'b1;
    @(posedge clk_sys_i) #1;
    we = 1'b0;
  endtask
  task automatic rdb(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk_sys_i) #1;
    a = ad;
    re = 1'b1;
    @(posedge clk_sys_i) #1;
    re = 1'b0;
    d = rd;
  endtask
  // write and read back the same subaddress on back-to-back edges
  task automatic wrrd(input logic [7:0] ad, input logic [7:0] wv, output logic [7:0] d);
    @(posedge clk_sys_i) #1;
    a = ad;
    wd = wv;
    we = 1'b1;
    @(posedge clk_sys_i) #1;
    we = 1'b0;
    re = 1'b1;
    @(posedge clk_sys_i) #1;
    re = 1'b0;
    d = rd;
  endtask
  task automatic prog(input logic [7:0] rb, input logic [7:0] rc, input logic [7:0] ctl);
    wr(ADDR_BIT_CLOCK_RATIO, rb);
    wr(ADDR_CHANNEL_CLOCK_RATIO, rc);
    wr(ADDR_AUDIO_CLOCK_CONTROL, ctl);
    wr(ADDR_NOMINAL_INCREMENT_HIGH, 8'h20);
  endtask
  // shortest and longest rise-to-rise interval of master, bit or channel clock
  task automatic meas(input int k, input int n, output int lo, output int hi);
    logic [2:0] p, s;
    int t;
    lo = 99999;
    hi = 0;
    t = -1;
    p = 3'b111;
    repeat (n) begin
      @(posedge clk_sys_i) #1;
      s = {lc, sc, mc};
      if (t >= 0) t++;
      if (s[k] && !p[k]) begin
        if (t > 0 && t < lo) lo = t;
        if (t > hi) hi = t;
        t = 0;
      end
      p = s;
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      rdb(RT[i][15:8], v);
      chk(v, 8'h00);
      wrrd(RT[i][15:8], 8'hFF, v);
      chk(v, RT[i][7:0]);
    end
  endtask
  task automatic t_clk();
    int lo, hi, e;
    for (int c = 0; c < 5; c++) begin
      rst();
      prog(c < 4 ? 8'h00 : 8'h3F, c < 4 ? 8'h01 : 8'h00, 8'h08 + 8'(c % 4));
      for (int k = 0; k < 3; k++) begin
        e = k == 0 ? 8 : k == 1 ? (c < 4 ? 16 : 1024) : (c < 4 ? 64 : 2048);
        meas(k, c < 4 ? 200 : 4200, lo, hi);
        chk(lo, e);
        chk(hi, e);
      end
      chk(bits, c < 4 ? 2 : 1);
    end
  endtask
  task automatic t_lock();
    int lo, hi;
    for (int i = 0; i < 5; i++) begin
      rst();
      {den, xen} = CS[i][5:4];
      // a large field target pushes the trim upwards, so no slow period may appear
      if (CS[i][6]) wr(ADDR_CYCLES_PER_FIELD_LOW, 8'hFF);
      prog(8'h00, 8'h00, {4'h0, CS[i][11:8]});
      meas(0, 800, lo, hi);
      chk(hi, CS[i][3:0]);
    end
    {den, xen} = 2'b00;
  endtask
  initial begin
    rst();
    t_regs();
    t_clk();
    t_lock();
    conclude();
  end
endmodule
